// ---- include/fcc_pkg.sv ----
// constants and types for the single-coil fan commutation controller
package fcc_pkg;

    // clock
    localparam int unsigned CLK_HZ            = 200_000_000;
    localparam int unsigned CLK_MHZ           = 200;

    // standby delay, microseconds
    localparam int unsigned STANDBY_DELAY_US  = 400;
    localparam int unsigned STANDBY_DELAY_CYC = STANDBY_DELAY_US * CLK_MHZ;

    // lock protection times, seconds
    localparam real         LOCK_DETECT_ON_S  = 0.5;
    localparam real         LOCK_OFF_S        = 4.5;
    localparam int unsigned LOCK_ON_CYC       = int'(LOCK_DETECT_ON_S * CLK_HZ);
    localparam int unsigned LOCK_OFF_CYC      = int'(LOCK_OFF_S * CLK_HZ);

    // triangle wave: 8-bit up/down ramp, 510 steps per period
    localparam int unsigned TRI_FREQ_HZ       = 36_000;
    localparam int unsigned TRI_STEPS         = 510;
    localparam int unsigned TRI_STEP_CYC      = CLK_HZ / (TRI_FREQ_HZ * TRI_STEPS);
    localparam logic [7:0]  TRI_PRE_LAST      = 8'(TRI_STEP_CYC - 1);
    localparam logic [7:0]  TRI_TOP           = 8'hFF;
    localparam logic [7:0]  TRI_BOTTOM        = 8'h00;

    // pin synchroniser bit positions
    localparam int unsigned PIN_PWM           = 0;
    localparam int unsigned PIN_HALL          = 1;
    localparam int unsigned PIN_ILIM          = 2;
    localparam int unsigned PIN_VMODE         = 3;
    localparam int unsigned PIN_N             = 4;

    // reset values
    localparam logic [31:0] CNT_RST           = 32'h0000_0000;
    localparam logic [7:0]  BYTE_RST          = 8'h00;

    typedef enum logic [1:0] {
        FCC_RUN = 2'b01,
        FCC_OFF = 2'b10
    } fcc_lock_t;

    typedef struct packed {
        logic [PIN_N-1:0] pin_s1;
        logic [PIN_N-1:0] pin_s2;
        logic [PIN_N-1:0] pin_s3;
        logic [PIN_N-1:0] pin_f;
        logic             hall_prev;
        logic [31:0]      low_cnt;
        logic             standby;
        logic [7:0]       tri_pre;
        logic [7:0]       tri_val;
        logic             tri_up;
        fcc_lock_t        lock_st;
        logic [31:0]      lock_cnt;
        logic             locked;
        logic             out_a;
        logic             out_b;
        logic             tach_oe;
        logic             lock_oe;
        logic             od_low;
    } fcc_state_t;

endpackage

// ---- verilog/fcc_ctrl.sv ----
// commutation, speed, standby and lock logic of the single-coil fan driver
`timescale 1ns/1ps
module fcc_ctrl
    import fcc_pkg::*;
#(
    parameter int unsigned STANDBY_CYC  = STANDBY_DELAY_CYC,
    parameter int unsigned LOCK_ON_CYCS = LOCK_ON_CYC,
    parameter int unsigned LOCK_OFF_CYCS = LOCK_OFF_CYC
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // pins, asynchronous
    input  wire logic       speed_pwm_i,
    input  wire logic       hall_cmp_i,
    input  wire logic       current_limit_i,
    input  wire logic       voltage_mode_i,
    // converted speed levels, same clock
    input  wire logic [7:0] speed_voltage_in_i,
    input  wire logic [7:0] min_speed_voltage_in_i,
    // bridge
    output logic            bridge_out_a_o,
    output logic            bridge_out_b_o,
    // open-drain outputs
    output logic            tach_out_o,
    output logic            tach_out_oe_o,
    output logic            lock_flag_o,
    output logic            lock_flag_oe_o,
    // status
    output logic            standby_o
);

    fcc_state_t st_reg;
    fcc_state_t st_next;

    logic       hall_edge;
    logic       int_pwm;
    logic       active_pwm;
    logic       drive_w;

    // clamp: the higher of the two levels sets the duty
    function automatic logic tri_cmp(input logic [7:0] spd, input logic [7:0] mn,
                                     input logic [7:0] tri_v);
        logic [7:0] lvl;
        lvl = (spd > mn) ? spd : mn;
        return lvl > tri_v;
    endfunction

    always_comb begin
        hall_edge  = st_reg.pin_f[PIN_HALL] ^ st_reg.hall_prev;
        int_pwm    = tri_cmp(speed_voltage_in_i, min_speed_voltage_in_i,
                             st_reg.tri_val);
        active_pwm = st_reg.pin_f[PIN_VMODE] ? int_pwm
                                             : st_reg.pin_f[PIN_PWM];
        drive_w    = active_pwm && !st_reg.standby && (st_reg.lock_st == FCC_RUN)
                     && !st_reg.pin_f[PIN_ILIM];

        st_next = st_reg;

        // three-stage sync; accept a change once stages two and three agree
        st_next.pin_s1    = {voltage_mode_i, current_limit_i, hall_cmp_i, speed_pwm_i};
        st_next.pin_s2    = st_reg.pin_s1;
        st_next.pin_s3    = st_reg.pin_s2;
        st_next.pin_f     = (st_reg.pin_s2 & st_reg.pin_s3)
                          | (st_reg.pin_f & (st_reg.pin_s2 | st_reg.pin_s3));
        st_next.hall_prev = st_reg.pin_f[PIN_HALL];

        // standby detection
        if (st_reg.pin_f[PIN_PWM]) begin
            st_next.low_cnt = CNT_RST;
            st_next.standby = 1'b0;
        end else if (st_reg.low_cnt == STANDBY_CYC) begin
            st_next.standby = 1'b1;
        end else begin
            st_next.low_cnt = st_reg.low_cnt + 32'h1;
        end

        // triangle ramp
        if (st_reg.tri_pre == TRI_PRE_LAST) begin
            st_next.tri_pre = BYTE_RST;
            if (st_reg.tri_up) begin
                st_next.tri_val = st_reg.tri_val + 8'h01;
                st_next.tri_up  = (st_reg.tri_val != (TRI_TOP - 8'h01));
            end else begin
                st_next.tri_val = st_reg.tri_val - 8'h01;
                st_next.tri_up  = (st_reg.tri_val == (TRI_BOTTOM + 8'h01));
            end
        end else begin
            st_next.tri_pre = st_reg.tri_pre + 8'h01;
        end

        // lock protection
        if (st_reg.standby) begin
            st_next.lock_st  = FCC_RUN;
            st_next.lock_cnt = CNT_RST;
            st_next.locked   = 1'b0;
        end else begin
            case (st_reg.lock_st)
                FCC_RUN: begin
                    if (hall_edge) begin
                        st_next.lock_cnt = CNT_RST;
                        st_next.locked   = 1'b0;
                    end else if (st_reg.lock_cnt == LOCK_ON_CYCS - 1) begin
                        st_next.lock_st  = FCC_OFF;
                        st_next.lock_cnt = CNT_RST;
                        st_next.locked   = 1'b1;
                    end else begin
                        st_next.lock_cnt = st_reg.lock_cnt + 32'h1;
                    end
                end
                FCC_OFF: begin
                    if (st_reg.lock_cnt == LOCK_OFF_CYCS - 1) begin
                        st_next.lock_st  = FCC_RUN;
                        st_next.lock_cnt = CNT_RST;
                    end else begin
                        st_next.lock_cnt = st_reg.lock_cnt + 32'h1;
                    end
                end
                default: begin
                    st_next.lock_st  = FCC_RUN;
                    st_next.lock_cnt = CNT_RST;
                end
            endcase
        end

        // bridge phase and open-drain outputs
        st_next.out_a   = drive_w && !st_reg.pin_f[PIN_HALL];
        st_next.out_b   = drive_w && st_reg.pin_f[PIN_HALL];
        st_next.tach_oe = st_reg.pin_f[PIN_HALL];
        st_next.lock_oe = !st_reg.locked;
        st_next.od_low  = 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '{pin_s1: 4'h0, pin_s2: 4'h0, pin_s3: 4'h0, pin_f: 4'h0,
                        hall_prev: 1'b0, low_cnt: CNT_RST, standby: 1'b0,
                        tri_pre: BYTE_RST, tri_val: BYTE_RST, tri_up: 1'b1,
                        lock_st: FCC_RUN, lock_cnt: CNT_RST, locked: 1'b0,
                        out_a: 1'b0, out_b: 1'b0, tach_oe: 1'b0, lock_oe: 1'b0,
                        od_low: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign bridge_out_a_o = st_reg.out_a;
    assign bridge_out_b_o = st_reg.out_b;
    assign tach_out_o     = st_reg.od_low;
    assign tach_out_oe_o  = st_reg.tach_oe;
    assign lock_flag_o    = st_reg.od_low;
    assign lock_flag_oe_o = st_reg.lock_oe;
    assign standby_o      = st_reg.standby;

    // checks
    sequence s_run_timeout;
        st_reg.lock_st == FCC_RUN && !st_reg.standby && !hall_edge
            && st_reg.lock_cnt == LOCK_ON_CYCS - 1;
    endsequence

    sequence s_off_done;
        st_reg.lock_st == FCC_OFF && !st_reg.standby
            && st_reg.lock_cnt == LOCK_OFF_CYCS - 1;
    endsequence

    a_standby_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !st_reg.pin_f[PIN_PWM] && st_reg.low_cnt == STANDBY_CYC |=> st_reg.standby)
        else $error("standby not entered after long low");

    a_standby_exit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_reg.pin_f[PIN_PWM] |=> !st_reg.standby && st_reg.low_cnt == CNT_RST)
        else $error("standby held while pwm high");

    a_ext_pwm_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !st_reg.pin_f[PIN_VMODE] && st_reg.pin_f[PIN_PWM] && !st_reg.standby
            && st_reg.lock_st == FCC_RUN && !st_reg.pin_f[PIN_ILIM]
        |=> bridge_out_a_o ^ bridge_out_b_o)
        else $error("bridge not driven with pwm high");

    a_regen_both_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !active_pwm |=> !bridge_out_a_o && !bridge_out_b_o)
        else $error("bridge driven while drive pwm low");

    a_phase_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        drive_w |=> bridge_out_b_o == $past(st_reg.pin_f[PIN_HALL])
            && bridge_out_a_o != bridge_out_b_o)
        else $error("wrong bridge phase");

    a_tach_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $changed(st_reg.pin_f[PIN_HALL]) |=> tach_out_oe_o == $past(st_reg.pin_f[PIN_HALL]))
        else $error("tach does not follow hall");

    a_lock_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_reg.lock_st == FCC_OFF |-> st_reg.locked ##1 !lock_flag_oe_o)
        else $error("lock flag not shown");

    a_current_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_reg.pin_f[PIN_ILIM] |=> !bridge_out_a_o && !bridge_out_b_o)
        else $error("bridge driven during current limit");

    a_voltage_clamp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_reg.pin_f[PIN_VMODE] && st_reg.tri_val < min_speed_voltage_in_i |-> active_pwm)
        else $error("minimum speed clamp lost");

    a_tri_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_reg.tri_pre == TRI_PRE_LAST && st_reg.tri_up && st_reg.tri_val != TRI_TOP
        |=> st_reg.tri_val == $past(st_reg.tri_val) + 8'h01 && st_reg.tri_pre == BYTE_RST)
        else $error("triangle step wrong");

    a_lock_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_run_timeout |=> st_reg.lock_st == FCC_OFF ##1 !bridge_out_a_o && !bridge_out_b_o)
        else $error("lock not declared after on-time");

    a_lock_retry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_off_done |=> st_reg.lock_st == FCC_RUN && st_reg.lock_cnt == CNT_RST)
        else $error("no retry after off-time");

    a_lock_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_reg.lock_st == FCC_RUN && hall_edge |=> !st_reg.locked ##1 lock_flag_oe_o)
        else $error("lock flag not cleared on hall edge");

endmodule // fcc_ctrl

// ---- test/fcc_hall_model.sv ----
// hall sensor model: spins with a fixed half period or holds a level
`timescale 1ns/1ps
module fcc_hall_model #(
    parameter int HALF_CYC = 20
) (
    // clock
    input  wire logic clk_i,
    // control
    input  wire logic rotate_i,
    input  wire logic hold_i,
    // sensor
    output logic      hall_cmp_o
);
    int cnt = 0;
    initial hall_cmp_o = 1'b0;
    // stalled rotor shows a fixed level, spinning one toggles
    always @(negedge clk_i) begin
        if (!rotate_i) begin
            hall_cmp_o <= hold_i;
            cnt <= 0;
        end else if (cnt == HALF_CYC - 1) begin
            hall_cmp_o <= !hall_cmp_o;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // fcc_hall_model

// ---- test/fcc_ctrl_tb.sv ----
// self-checking bench of the fan commutation controller
`timescale 1ns/1ps
module fcc_ctrl_tb;
    import fcc_pkg::*;
    localparam int SB   = 20;
    localparam int LON  = 50;
    localparam int LOFF = 200;
    typedef struct { bit kind; logic [31:0] exp; string name; } fcc_note_t;

    logic        clk, rst_n, pwm, ilim, vmode, rot, hold, hall;
    logic [7:0]  spd, mins, lvl;
    logic        out_a, out_b, tach, tach_oe, lockf, lock_oe, standby;
    logic [31:0] rnd, meas;
    int          num_errors = 0;
    int          compares = 0;
    fcc_note_t   notes[$];
    fcc_note_t   note;
    event        req;
    wire  [4:0]  out_vec   = {standby, lock_oe, tach_oe, out_b, out_a};
    wire         tach_wire = tach_oe ? tach : 1'b1;
    wire         lock_wire = lock_oe ? lockf : 1'b1;
    wire         drv       = out_a | out_b;

    fcc_ctrl #(.STANDBY_CYC(SB), .LOCK_ON_CYCS(LON), .LOCK_OFF_CYCS(LOFF)) dut (
        .clk_i(clk), .rst_n_i(rst_n), .speed_pwm_i(pwm), .hall_cmp_i(hall),
        .current_limit_i(ilim), .voltage_mode_i(vmode), .speed_voltage_in_i(spd),
        .min_speed_voltage_in_i(mins), .bridge_out_a_o(out_a), .bridge_out_b_o(out_b),
        .tach_out_o(tach), .tach_out_oe_o(tach_oe), .lock_flag_o(lockf),
        .lock_flag_oe_o(lock_oe), .standby_o(standby));
    fcc_hall_model #(.HALF_CYC(20)) hall_m (
        .clk_i(clk), .rotate_i(rot), .hold_i(hold), .hall_cmp_o(hall));

    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] ev(logic sb, logic lk, logic h, logic d);
        return 32'({sb, lk, h, d & h, d & !h});
    endfunction
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic note_exp(bit kind, logic [31:0] exp, string name);
        notes.push_back('{kind, exp, name});
        ->req;
        #1;
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic run_len(logic l, int lim);
        meas = 0;
        while (drv === l && meas < lim) begin
            @(posedge clk);
            #1;
            meas++;
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    // oldest note against what the outputs show
    initial forever begin
        @(req);
        note = notes.pop_front();
        check(note.name, note.kind ? meas : 32'(out_vec), note.exp);
    end
    initial begin
        #200_000;
        num_errors++;
        stop_test();
    end

    initial begin
        {rst_n, ilim, vmode, rot, hold} = 5'h00;
        pwm = 1'b1;
        spd = 8'h00;
        mins = 8'hFF;
        rnd = 32'hF4BB5AD1;
        cyc(10);
        note_exp(0, 32'h0, "reset_outputs");
        cyc(6);
        rst_n = 1'b1;
        for (int i = 0; i < 32; i++) begin
            rnd = lfsr(rnd);
            hold = !hold;
            pwm = rnd[0] | !pwm;
            ilim = rnd[1] & rnd[2];
            cyc(7);
            note_exp(0, ev(0, 1, hold, pwm & !ilim), "truth");
            meas = 32'({tach_wire, lock_wire});
            note_exp(1, 32'({!hold, 1'b0}), "od_pins");
        end
        cyc(1);
        {hold, pwm, ilim} = {!hold, 2'b00};
        cyc(SB + 2);
        note_exp(0, ev(0, 1, hold, 0), "short_low");
        cyc(8);
        note_exp(0, ev(1, 1, hold, 0), "standby");
        cyc(1);
        pwm = 1'b1;
        cyc(7);
        note_exp(0, ev(0, 1, hold, 1), "wake");
        cyc(1);
        {vmode, rot} = 2'b11;
        for (int k = 0; k < 4; k++) begin
            spd = k[0] ? 8'h00 : (k[1] ? 8'hFF : 8'h80);
            mins = k[0] ? (k[1] ? 8'h00 : 8'h40) : 8'h10;
            lvl = spd > mins ? spd : mins;
            cyc(20);
            run_len(drv, 0);
            repeat (TRI_STEPS * TRI_STEP_CYC) begin
                @(posedge clk);
                #1;
                if (drv)
                    meas++;
            end
            note_exp(1, (lvl == 0 ? 0 : 2 * lvl - 1) * TRI_STEP_CYC, "duty");
            cyc(1);
        end
        {vmode, rot} = 2'b00;
        hold = !hold;
        // let the pwm-mode drive come up before timing the lock cycle
        cyc(8);
        run_len(1, 4 * LON);
        run_len(0, LOFF + 40);
        note_exp(1, LOFF, "off_time");
        run_len(1, LON + 40);
        note_exp(1, LON, "on_time");
        cyc(2);
        note_exp(0, ev(0, 0, hold, 0), "locked");
        meas = 32'(lock_wire);
        note_exp(1, 32'h1, "lock_pin");
        cyc(1);
        rot = 1'b1;
        for (int w = 0; w < 2 * LOFF && lock_oe !== 1'b1; w++) begin
            @(posedge clk);
            #1;
        end
        meas = 32'(lock_oe);
        note_exp(1, 1, "lock_cleared");
        stop_test();
    end
endmodule // fcc_ctrl_tb
